// ==== verification/ocg_chan_model.sv ====
/*
  Channel array model: answers channel reads of the global bank.
  Assumes chan_reg holds its value while a read is in flight.
*/
`timescale 1ns/1ps

module ocg_chan_model (
  // Clock and reset
  input wire logic clk,
  input wire logic rst,
  // Channel port
  input wire logic chan_rd,
  input wire logic [3:0] chan_reg,
  output logic [63:0] chan_rdata
);
  logic rd_d;

  // Read window covers the strobe cycle and the one after it
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      rd_d <= 1'b0;
    end else begin
      rd_d <= chan_rd;
    end
  end

  // Byte n names its channel and offset; outside the window the
  // inverse shows, so an early or late sample cannot match
  always_comb begin
    for (int n = 0; n < 8; n++) begin
      chan_rdata[8*n +: 8] = {1'b1, 3'(n), chan_reg};
      if (!(chan_rd || rd_d)) begin
        chan_rdata[8*n +: 8] = ~chan_rdata[8*n +: 8];
      end
    end
  end
endmodule // ocg_chan_model

// ==== verification/ocg_global_regs_tb_top.sv ====
/*
  Testbench for the global configuration bank: host bus tasks and
  directed register sequences. Assumes the channel model answers reads.
*/
`timescale 1ns/1ps

module ocg_global_regs_tb_top;
  logic clk = 1'b0, rst = 1'b1, cs_n = 1'b1, rd_n = 1'b1, wr_n = 1'b1;
  logic [7:0] addr = 8'h00, data_in = 8'h00, data_out, chan_sel;
  logic [7:0] chan_wdata, sample_8x, sleep_en, soft_reset;
  logic [7:0] ch_irq_req = 8'h00, ch_irq_en = 8'h00, rd_v, w_sel, w_dat;
  logic [7:0] sr_seen = 8'h00;
  logic [23:0] ch_code = 24'h000000, exp_codes;
  logic [63:0] chan_rdata;
  logic [15:0] timer_value;
  logic [3:0] chan_reg, w_reg;
  logic data_oe_n, chan_enhanced, chan_wr, chan_rd, irq, w_enh;
  logic timer_timeout = 1'b0, wake_event = 1'b0, timer_irq_en;
  logic timer_start, timer_func_sel, timer_clk_src;
  int n_fail = 0, samples_checked = 0, ts_cnt = 0;
  logic [7:0] ro_a [6] = '{8'h80, 8'h85, 8'h89, 8'h8a, 8'h8c, 8'h8d};
  logic [7:0] ro_e [6] = '{8'h00, 8'h00, 8'h00, 8'h00, 8'h5a, 8'ha5};
  logic [7:0] rw_a [4] = '{8'h86, 8'h87, 8'h88, 8'h8b};
  logic [7:0] rw_d [4] = '{8'h34, 8'h12, 8'ha5, 8'h3c};
  logic [2:0] code_tab [8] = '{3'h2, 3'h1, 3'h3, 3'h7, 3'h4, 3'h1, 3'h2,
    3'h3};

  always #10 clk = ~clk;

  ocg_global_regs dut (.clk(clk), .rst(rst), .cs_n(cs_n), .rd_n(rd_n),
    .wr_n(wr_n), .addr(addr), .data_in(data_in), .data_out(data_out),
    .data_oe_n(data_oe_n), .chan_sel(chan_sel), .chan_reg(chan_reg),
    .chan_enhanced(chan_enhanced), .chan_wr(chan_wr), .chan_rd(chan_rd),
    .chan_wdata(chan_wdata), .chan_rdata(chan_rdata),
    .ch_irq_req(ch_irq_req), .ch_irq_en(ch_irq_en), .ch_code(ch_code),
    .timer_timeout(timer_timeout), .wake_event(wake_event),
    .timer_irq_en(timer_irq_en), .timer_start(timer_start),
    .timer_func_sel(timer_func_sel), .timer_clk_src(timer_clk_src),
    .timer_value(timer_value), .sample_8x(sample_8x),
    .sleep_en(sleep_en), .soft_reset(soft_reset), .irq(irq));

  ocg_chan_model chans (.clk(clk), .rst(rst), .chan_rd(chan_rd),
    .chan_reg(chan_reg), .chan_rdata(chan_rdata));

  // Pulses are caught here since they last a single cycle
  always @(posedge clk) begin
    if (chan_wr === 1'b1) begin
      {w_sel, w_reg, w_enh, w_dat} <= {chan_sel, chan_reg, chan_enhanced,
        chan_wdata};
    end
    if (soft_reset !== 8'h00) sr_seen <= soft_reset;
    if (timer_start === 1'b1) ts_cnt <= ts_cnt + 1;
  end

  // ----------------------------------------------------------------
  // Host bus tasks
  // ----------------------------------------------------------------
  task automatic check(input string nm, input logic [31:0] seen,
    input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      n_fail++;
      $display("[ERR] %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  // Strobes stay low until the answer, then two more cycles for channels
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    int i;
    i = 0;
    @(negedge clk);
    {cs_n, rd_n, addr} = {2'b00, a};
    while (data_oe_n !== 1'b0 && i < 20) begin
      @(negedge clk);
      i++;
    end
    if (i >= 20) check("read_answer", 0, 1);
    repeat (2) @(negedge clk);
    d = data_out;
    {cs_n, rd_n} = 2'b11;
    repeat (4) @(negedge clk);
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(negedge clk);
    {cs_n, wr_n, addr, data_in} = {2'b00, a, d};
    repeat (4) @(negedge clk);
    {cs_n, wr_n} = 2'b11;
    repeat (4) @(negedge clk);
  endtask

  task automatic pulse(ref logic s);
    @(negedge clk);
    s = 1'b1;
    @(negedge clk);
    s = 1'b0;
    repeat (3) @(negedge clk);
  endtask

  task automatic end_of_test;
    $display("checks %0d mismatches %0d", samples_checked, n_fail);
    if (n_fail == 0 && samples_checked > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask

  // Watchdog well above the several hundred cycles the run needs
  initial begin
    repeat (30000) @(posedge clk);
    n_fail++;
    end_of_test();
  end

  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  initial begin
    repeat (10) @(negedge clk);
    rst = 1'b0;
    repeat (3) @(negedge clk);
    for (int a = 0; a < 4; a++) begin
      rd(8'h80 + 8'(a), rd_v);
      check("irq_regs", rd_v, 8'h00);
    end
    check("irq", irq, 1'b0);
    // Read-only, reserved and write-only bytes must read back unchanged after writes
    foreach (ro_a[i]) begin
      wr(ro_a[i], 8'hff);
      rd(ro_a[i], rd_v);
      check("ro_reg", rd_v, ro_e[i]);
    end
    foreach (rw_a[i]) begin
      wr(rw_a[i], rw_d[i]);
      rd(rw_a[i], rd_v);
      check("rw_reg", rd_v, rw_d[i]);
    end
    check("timer_value", timer_value, 16'h1234);
    check("sample_8x", sample_8x, 8'ha5);
    check("sleep_en", sleep_en, 8'h3c);
    sr_seen = 8'h00;
    wr(8'h8a, 8'h81);
    check("soft_reset", sr_seen, 8'h81);
    // Broadcast reaches every channel on writes only
    wr(8'h8e, 8'hff);
    rd(8'h8e, rd_v);
    check("bcast_reg", rd_v, 8'h01);
    wr(8'h35, 8'h66);
    check("bcast_sel", w_sel, 8'hff);
    wr(8'h8e, 8'h00);
    for (int n = 0; n < 8; n++) begin
      wr(8'(n * 18 + 1), 8'(n));
      check("ch_wr", {w_sel, w_reg, w_enh, w_dat}, {8'h01 << n,
        4'(2 * n + 1), n >= 4, 8'(n)});
      rd(8'(n * 18 + 1), rd_v);
      check("ch_rd", rd_v, {1'b1, 3'(n), 4'(2 * n + 1)});
    end
    // Timer: commands, pending flag, clear on read, mask
    wr(8'h84, 8'h0f);
    check("timer_start", ts_cnt, 1);
    check("timer_ctl", {timer_clk_src, timer_func_sel, timer_irq_en},
      3'b111);
    rd(8'h84, rd_v);
    check("timer_idle", rd_v, 8'h00);
    pulse(timer_timeout);
    check("irq_timer", irq, 1'b1);
    rd(8'h81, rd_v);
    check("timer_code", rd_v, 8'h07);
    rd(8'h84, rd_v);
    check("timer_pend", rd_v, 8'h01);
    rd(8'h84, rd_v);
    check("timer_clr", rd_v, 8'h00);
    wr(8'h84, 8'h00);
    pulse(timer_timeout);
    rd(8'h84, rd_v);
    check("timer_mask", rd_v, 8'h00);
    // Channel requests gated by their enables; code 7 barred off ch0
    ch_irq_en = 8'h5a;
    exp_codes = 24'h000000;
    for (int n = 0; n < 8; n++) begin
      ch_code[3*n +: 3] = code_tab[n];
      if (ch_irq_en[n] && code_tab[n] != 3'h7) begin
        exp_codes[3*n +: 3] = code_tab[n];
      end
    end
    ch_irq_req = 8'hff;
    repeat (3) @(negedge clk);
    check("irq_ch", irq, 1'b1);
    for (int k = 0; k < 2; k++) begin
      rd(8'h80, rd_v);
      check("summary", rd_v, 8'h5a);
      for (int a = 0; a < 3; a++) begin
        rd(8'h81 + 8'(a), rd_v);
        check("codes", rd_v, exp_codes[8*a +: 8]);
      end
    end
    ch_irq_req = 8'h00;
    repeat (3) @(negedge clk);
    check("irq_off", irq, 1'b0);
    // Wake interrupt needs all eight channels asleep
    wr(8'h8b, 8'hff);
    pulse(wake_event);
    rd(8'h80, rd_v);
    check("wake_sum", rd_v, 8'h01);
    rd(8'h81, rd_v);
    check("wake_code", rd_v, 8'h00);
    rd(8'h02, rd_v);
    rd(8'h80, rd_v);
    check("wake_clr", rd_v, 8'h00);
    wr(8'h8b, 8'h7f);
    pulse(wake_event);
    rd(8'h80, rd_v);
    check("wake_part", rd_v, 8'h00);
    end_of_test();
  end
endmodule // ocg_global_regs_tb_top

// ==== verilog/ocg_global_regs.sv ====
/*
  Global configuration register bank and address decoder of an
  eight-channel UART. Holds the host bus slave, interrupt summary and
  source codes, timer setup, sampling, soft reset, sleep, broadcast and
  identity registers. Assumes the channel logic and the timer share clk,
  and the host bus pins are asynchronous to clk.
*/
// Functional notes
// [RULE1] Each channel owns one 16-byte address block
// [RULE2] Global registers sit directly at 0x80-0x8f
// [RULE3] Whole map fits one 256-byte window
// [RULE4] Summary register: one bit per channel
// [RULE5] Three registers pack 3-bit codes, channel 0 lowest
// [RULE6] Summary and code registers reset to zero
// [RULE7] Channel enable gates its global contribution
// [RULE8] Timer and wake interrupts masked globally
// [RULE9] Wake interrupt only if all channels slept
// [RULE10] Only channel status reads clear indications; the timer flag clears on a timer control read
// [RULE11] Timer control low four bits, upper zero
// [RULE12] Sixteen-bit timer value, low byte first
// [RULE13] Per-channel 8X sampling select register
// [RULE14] Write-only per-channel soft reset
// [RULE15] Per-channel sleep enable register
// [RULE16] Broadcast bit copies channel writes everywhere
// [RULE17] Fixed revision then identification code
// [RULE18] Low eight channel registers legacy, rest enhanced
// [RULE19] Code zero none; code seven channel 0 only
// [RULE20] Reserved reads zero, read-only writes ignored
// [RULE21] Interrupt output follows any summary bit
`timescale 1ns/1ps

module ocg_global_regs #(
  parameter int NUM_CH = ocg_pkg::NUM_CH,
  parameter logic [7:0] REVISION_CODE = 8'h5a, // Arbitrary value
  parameter logic [7:0] IDENT_CODE = 8'ha5 // Arbitrary value
) (
  // Clock and reset
  input wire logic clk,
  input wire logic rst,
  // Host bus pins
  input wire logic cs_n,
  input wire logic rd_n,
  input wire logic wr_n,
  input wire logic [7:0] addr,
  input wire logic [7:0] data_in,
  output logic [7:0] data_out,
  output logic data_oe_n,
  // Channel access port
  output logic [7:0] chan_sel,
  output logic [3:0] chan_reg,
  output logic chan_enhanced,
  output logic chan_wr,
  output logic chan_rd,
  output logic [7:0] chan_wdata,
  input wire logic [63:0] chan_rdata,
  // Channel interrupt state
  input wire logic [7:0] ch_irq_req,
  input wire logic [7:0] ch_irq_en,
  input wire logic [23:0] ch_code,
  // Timer, sampling, soft reset and sleep interface
  input wire logic timer_timeout,
  input wire logic wake_event,
  output logic timer_irq_en,
  output logic timer_start,
  output logic timer_func_sel,
  output logic timer_clk_src,
  output logic [15:0] timer_value,
  output logic [7:0] sample_8x,
  output logic [7:0] sleep_en,
  output logic [7:0] soft_reset,
  // Device interrupt
  output logic irq
);

  // ----------------------------------------------------------------
  // Elaboration checks and decode helpers
  // ----------------------------------------------------------------
  if (NUM_CH != 8) begin : g_bad_ch
    $error("ocg_global_regs serves exactly eight channels");
  end

  // Global block is the one directly above the channel blocks
  function automatic logic is_global(input logic [7:0] a);
    return a[7:4] == ocg_pkg::GLOBAL_BASE[7:4];
  endfunction

  function automatic logic [7:0] chan_onehot(input logic [7:0] a);
    return 8'h01 << a[6:4];
  endfunction

  // ----------------------------------------------------------------
  // Pin synchronisers
  // ----------------------------------------------------------------
  logic [18:0] pin_s1_reg;
  logic [18:0] pin_s2_reg;

  // Two stages on every bus pin; stage one feeds stage two only
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      pin_s1_reg <= 19'h7ff00;
      pin_s2_reg <= 19'h7ff00;
    end else begin
      pin_s1_reg <= {cs_n, rd_n, wr_n, addr, data_in};
      pin_s2_reg <= pin_s1_reg;
    end
  end

  logic rd_act;
  logic wr_act;
  logic [7:0] bus_addr;
  logic [7:0] bus_data;
  assign rd_act = ~pin_s2_reg[18] & ~pin_s2_reg[17];
  assign wr_act = ~pin_s2_reg[18] & ~pin_s2_reg[16];
  assign bus_addr = pin_s2_reg[15:8];
  assign bus_data = pin_s2_reg[7:0];

  // ----------------------------------------------------------------
  // Access sequencer
  // ----------------------------------------------------------------
  ocg_pkg::ocg_state_t st_reg;
  logic rd_start;
  logic wr_start;
  logic glb_rd;
  logic glb_wr;
  assign rd_start = (st_reg == ocg_pkg::ST_IDLE) & rd_act;
  assign wr_start = (st_reg == ocg_pkg::ST_IDLE) & wr_act & ~rd_act;
  assign glb_rd = rd_start & is_global(bus_addr); // [RULE2]
  assign glb_wr = wr_start & is_global(bus_addr); // [RULE2]

  // One access per strobe; hold until the host lets go
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      st_reg <= ocg_pkg::ST_IDLE;
    end else begin
      unique case (st_reg)
        ocg_pkg::ST_IDLE: begin
          if (rd_start && !glb_rd) begin
            st_reg <= ocg_pkg::ST_RDWAIT;
          end else if (rd_start || wr_start) begin
            st_reg <= ocg_pkg::ST_HOLD;
          end
        end
        ocg_pkg::ST_RDWAIT: begin
          st_reg <= ocg_pkg::ST_HOLD;
        end
        ocg_pkg::ST_HOLD: begin
          if (!rd_act && !wr_act) begin
            st_reg <= ocg_pkg::ST_IDLE;
          end
        end
        default: begin
          st_reg <= ocg_pkg::ST_IDLE;
        end
      endcase
    end
  end

  // ----------------------------------------------------------------
  // Channel access port
  // ----------------------------------------------------------------
  logic bcast_reg;
  logic [7:0] chan_sel_reg;
  logic [3:0] chan_reg_reg;
  logic chan_wr_reg;
  logic chan_rd_reg;
  logic [7:0] chan_wdata_reg;
  logic [2:0] chan_idx_reg;

  // Accesses below 0x80 go to one channel; broadcast copies writes
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      chan_sel_reg <= ocg_pkg::RST_BYTE;
      chan_reg_reg <= 4'h0;
      chan_wr_reg <= 1'b0;
      chan_rd_reg <= 1'b0;
      chan_wdata_reg <= ocg_pkg::RST_BYTE;
      chan_idx_reg <= 3'h0;
    end else begin
      chan_wr_reg <= wr_start & ~is_global(bus_addr);
      chan_rd_reg <= rd_start & ~is_global(bus_addr);
      if ((rd_start || wr_start) && !is_global(bus_addr)) begin
        chan_reg_reg <= bus_addr[3:0]; // [RULE1]
        chan_idx_reg <= bus_addr[6:4]; // [RULE1]
        chan_wdata_reg <= bus_data;
        if (wr_start && bcast_reg) begin
          chan_sel_reg <= ocg_pkg::ALL_CH; // [RULE16]
        end else begin
          chan_sel_reg <= chan_onehot(bus_addr); // [RULE1] [RULE3]
        end
      end
    end
  end

  // ----------------------------------------------------------------
  // Writable global registers
  // ----------------------------------------------------------------
  logic [3:0] tctl_reg;
  logic timer_start_reg;
  logic [15:0] timer_value_reg;
  logic [7:0] sample_reg;
  logic [7:0] sleep_reg;
  logic [7:0] soft_reset_reg;

  // Writes to read-only and reserved offsets fall through unstored
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      tctl_reg <= 4'h0;
      timer_start_reg <= 1'b0;
      timer_value_reg <= 16'h0000;
      sample_reg <= ocg_pkg::RST_BYTE;
      sleep_reg <= ocg_pkg::RST_BYTE;
      soft_reset_reg <= ocg_pkg::RST_BYTE;
      bcast_reg <= 1'b0;
    end else begin
      timer_start_reg <= 1'b0;
      soft_reset_reg <= ocg_pkg::RST_BYTE;
      if (glb_wr) begin
        unique case (bus_addr)
          ocg_pkg::OFS_TIMER_CTRL: begin
            tctl_reg <= bus_data[3:0]; // [RULE11] [RULE8]
            timer_start_reg <= bus_data[ocg_pkg::TCTL_START]; // [RULE11]
          end
          ocg_pkg::OFS_TIMER_LOW: timer_value_reg[7:0] <= bus_data;
          ocg_pkg::OFS_TIMER_HIGH: timer_value_reg[15:8] <= bus_data;
          ocg_pkg::OFS_SAMPLE_SEL: sample_reg <= bus_data; // [RULE13]
          ocg_pkg::OFS_SOFT_RESET: soft_reset_reg <= bus_data; // [RULE14]
          ocg_pkg::OFS_SLEEP_EN: sleep_reg <= bus_data; // [RULE15]
          ocg_pkg::OFS_BCAST: bcast_reg <= bus_data[ocg_pkg::BCAST_BIT];
          default: begin
          end
        endcase
      end
    end
  end
  // The value above is the reload setup, not the live count [RULE12]

  // ----------------------------------------------------------------
  // Interrupt pending flags
  // ----------------------------------------------------------------
  logic timer_pend_reg;
  logic wake_pend_reg;
  logic ch0_isr_rd;
  assign ch0_isr_rd = chan_rd_reg & chan_sel_reg[0] &
                      (chan_reg_reg == ocg_pkg::CH_OFS_ISR);

  // A new event in the clearing cycle keeps the flag set
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      timer_pend_reg <= 1'b0;
      wake_pend_reg <= 1'b0;
    end else begin
      if (timer_timeout && tctl_reg[ocg_pkg::TCTL_IRQ_EN]) begin
        timer_pend_reg <= 1'b1; // [RULE8]
      end else if (glb_rd && bus_addr == ocg_pkg::OFS_TIMER_CTRL) begin
        timer_pend_reg <= 1'b0;
      end
      if (wake_event && sleep_reg == ocg_pkg::ALL_CH) begin
        wake_pend_reg <= 1'b1; // [RULE9] [RULE8]
      end else if (ch0_isr_rd) begin
        wake_pend_reg <= 1'b0; // [RULE10]
      end
    end
  end

  // ----------------------------------------------------------------
  // Summary and source codes
  // ----------------------------------------------------------------
  logic [7:0] summary_next;
  logic [23:0] codes_next;
  logic [7:0] summary_reg;
  logic [23:0] codes_reg;
  logic irq_reg;

  // Channels clear their own request on CHANNEL_IRQ_STATUS, CHANNEL_LINE_STATUS or CHANNEL_MODEM_STATUS reads
  for (genvar i = 0; i < 8; i++) begin : g_ch
    logic live;
    logic [2:0] raw;
    assign live = ch_irq_req[i] & ch_irq_en[i]; // [RULE7] [RULE10]
    assign raw = live ? ch_code[3*i +: 3] : ocg_pkg::CODE_NONE;
    if (i == 0) begin : g_ch0
      assign summary_next[i] = live | timer_pend_reg | wake_pend_reg;
      // Timer code is the lowest priority, shown only when channel 0 raises no code
      assign codes_next[2:0] =
          (raw == ocg_pkg::CODE_NONE && timer_pend_reg) ?
          ocg_pkg::CODE_TIMER : raw; // [RULE19]
    end else begin : g_chn
      assign summary_next[i] = live; // [RULE4]
      assign codes_next[3*i +: 3] = (raw == ocg_pkg::CODE_TIMER) ?
          ocg_pkg::CODE_NONE : raw; // [RULE19] [RULE5]
    end
  end

  // Registered view; all zero from reset
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      summary_reg <= ocg_pkg::RST_BYTE; // [RULE6]
      codes_reg <= ocg_pkg::RST_CODES; // [RULE6]
      irq_reg <= 1'b0;
    end else begin
      summary_reg <= summary_next;
      codes_reg <= codes_next;
      irq_reg <= |summary_next; // [RULE21]
    end
  end

  // ----------------------------------------------------------------
  // Read data path
  // ----------------------------------------------------------------
  logic [7:0] glb_rdata;
  logic [7:0] data_out_reg;
  logic data_oe_n_reg;

  // Reserved offsets and unused bits read as zero
  always_comb begin
    glb_rdata = ocg_pkg::RST_BYTE; // [RULE20]
    unique case (bus_addr)
      ocg_pkg::OFS_IRQ_SUMMARY: glb_rdata = summary_reg; // [RULE4]
      ocg_pkg::OFS_CODE_LOW: glb_rdata = codes_reg[7:0]; // [RULE5]
      ocg_pkg::OFS_CODE_MID: glb_rdata = codes_reg[15:8]; // [RULE5]
      ocg_pkg::OFS_CODE_HIGH: glb_rdata = codes_reg[23:16]; // [RULE5]
      ocg_pkg::OFS_TIMER_CTRL: glb_rdata = {7'h00, timer_pend_reg};
      ocg_pkg::OFS_TIMER_LOW: glb_rdata = timer_value_reg[7:0];
      ocg_pkg::OFS_TIMER_HIGH: glb_rdata = timer_value_reg[15:8];
      ocg_pkg::OFS_SAMPLE_SEL: glb_rdata = sample_reg;
      ocg_pkg::OFS_SLEEP_EN: glb_rdata = sleep_reg;
      ocg_pkg::OFS_REVISION: glb_rdata = REVISION_CODE; // [RULE17]
      ocg_pkg::OFS_IDENT: glb_rdata = IDENT_CODE; // [RULE17]
      ocg_pkg::OFS_BCAST: glb_rdata = {7'h00, bcast_reg}; // [RULE16]
      default: glb_rdata = ocg_pkg::RST_BYTE;
    endcase
  end

  // Channel data is taken at the end of the channel strobe cycle (ST_RDWAIT)
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      data_out_reg <= ocg_pkg::RST_BYTE;
      data_oe_n_reg <= 1'b1;
    end else begin
      data_oe_n_reg <= ~rd_act;
      if (glb_rd) begin
        data_out_reg <= glb_rdata;
      end else if (st_reg == ocg_pkg::ST_RDWAIT) begin
        data_out_reg <= chan_rdata[{chan_idx_reg, 3'h0} +: 8];
      end
    end
  end

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------
  assign data_out = data_out_reg;
  assign data_oe_n = data_oe_n_reg;
  assign chan_sel = chan_sel_reg;
  assign chan_reg = chan_reg_reg;
  assign chan_enhanced = chan_reg_reg[3]; // [RULE18]
  assign chan_wr = chan_wr_reg;
  assign chan_rd = chan_rd_reg;
  assign chan_wdata = chan_wdata_reg;
  assign timer_irq_en = tctl_reg[ocg_pkg::TCTL_IRQ_EN];
  assign timer_start = timer_start_reg;
  assign timer_func_sel = tctl_reg[ocg_pkg::TCTL_FUNC];
  assign timer_clk_src = tctl_reg[ocg_pkg::TCTL_CLKSRC];
  assign timer_value = timer_value_reg;
  assign sample_8x = sample_reg;
  assign sleep_en = sleep_reg;
  assign soft_reset = soft_reset_reg;
  assign irq = irq_reg;

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  sequence s_chan_rd_req;
    rd_start && !is_global(bus_addr);
  endsequence

  sequence s_chan_rd_done;
    chan_rd_reg ##1 (st_reg == ocg_pkg::ST_HOLD);
  endsequence

  property p_irq_follows;
    @(posedge clk) disable iff (rst) irq == (summary_reg != 8'h00);
  endproperty
  a_irq_follows: assert property (p_irq_follows) // [RULE21]
    else $error("irq does not match summary");

  property p_onehot_read;
    @(posedge clk) disable iff (rst)
      chan_rd_reg |-> (chan_sel_reg == (8'h01 << chan_idx_reg));
  endproperty
  a_onehot_read: assert property (p_onehot_read) // [RULE1]
    else $error("channel read not one-hot");

  property p_global_no_chan;
    @(posedge clk) disable iff (rst)
      (rd_start || wr_start) && is_global(bus_addr) |=>
        !chan_rd_reg && !chan_wr_reg;
  endproperty
  a_global_no_chan: assert property (p_global_no_chan) // [RULE2]
    else $error("global access reached a channel");

  property p_chan_read;
    @(posedge clk) disable iff (rst) s_chan_rd_req |=> s_chan_rd_done;
  endproperty
  a_chan_read: assert property (p_chan_read) // [RULE3]
    else $error("channel read sequence broken");

  property p_bcast;
    @(posedge clk) disable iff (rst)
      wr_start && !is_global(bus_addr) && bcast_reg |=>
        chan_wr_reg && chan_sel_reg == 8'hff;
  endproperty
  a_bcast: assert property (p_bcast) // [RULE16]
    else $error("broadcast write not to all channels");

  property p_timer_clear;
    @(posedge clk) disable iff (rst)
      glb_rd && bus_addr == ocg_pkg::OFS_TIMER_CTRL && !timer_timeout
        |=> !timer_pend_reg;
  endproperty
  a_timer_clear: assert property (p_timer_clear) // [RULE8]
    else $error("timer pending not cleared by control read");

  property p_code7_ch0;
    @(posedge clk) disable iff (rst)
      codes_reg[5:3] != 3'h7 && codes_reg[23:21] != 3'h7;
  endproperty
  a_code7_ch0: assert property (p_code7_ch0) // [RULE19]
    else $error("timer code outside channel 0");

  property p_reset_pulse;
    @(posedge clk) disable iff (rst)
      soft_reset_reg != 8'h00 |=> soft_reset_reg == 8'h00;
  endproperty
  a_reset_pulse: assert property (p_reset_pulse) // [RULE14]
    else $error("soft reset longer than one cycle");

  property p_code_zero;
    @(posedge clk) disable iff (rst)
      !summary_reg[1] |-> codes_reg[5:3] == 3'h0;
  endproperty
  a_code_zero: assert property (p_code_zero) // [RULE6]
    else $error("code set without summary bit");

  property p_wake_mask;
    @(posedge clk) disable iff (rst)
      $rose(wake_pend_reg) |-> $past(sleep_reg) == 8'hff;
  endproperty
  a_wake_mask: assert property (p_wake_mask) // [RULE9]
    else $error("wake interrupt without full sleep");

endmodule // ocg_global_regs

// ==== verilog/ocg_pkg.sv ====
/*
  Package for the octal UART global configuration bank: address map,
  register offsets, field positions, reset values and bus states.
  Assumes nothing of its surroundings; every user names it explicitly.
*/
package ocg_pkg;

  // ----------------------------------------------------------------
  // Address map
  // ----------------------------------------------------------------
  localparam int ADDR_W = 8;
  localparam int DATA_W = 8;
  localparam int NUM_CH = 8;
  localparam int CODE_W = 3;
  localparam logic [7:0] GLOBAL_BASE = 8'h80;
  localparam logic [3:0] LEGACY_TOP = 4'h7; // Last legacy-layout offset

  // Global register offsets
  localparam logic [7:0] OFS_IRQ_SUMMARY = 8'h80;
  localparam logic [7:0] OFS_CODE_LOW = 8'h81;
  localparam logic [7:0] OFS_CODE_MID = 8'h82;
  localparam logic [7:0] OFS_CODE_HIGH = 8'h83;
  localparam logic [7:0] OFS_TIMER_CTRL = 8'h84;
  localparam logic [7:0] OFS_TIMER_RSVD = 8'h85;
  localparam logic [7:0] OFS_TIMER_LOW = 8'h86;
  localparam logic [7:0] OFS_TIMER_HIGH = 8'h87;
  localparam logic [7:0] OFS_SAMPLE_SEL = 8'h88;
  localparam logic [7:0] OFS_GEN_RSVD_A = 8'h89;
  localparam logic [7:0] OFS_SOFT_RESET = 8'h8a;
  localparam logic [7:0] OFS_SLEEP_EN = 8'h8b;
  localparam logic [7:0] OFS_REVISION = 8'h8c;
  localparam logic [7:0] OFS_IDENT = 8'h8d;
  localparam logic [7:0] OFS_BCAST = 8'h8e;

  // Channel register offsets whose read clears a pending interrupt
  localparam logic [3:0] CH_OFS_ISR = 4'h2;
  localparam logic [3:0] CH_OFS_LSR = 4'h5;
  localparam logic [3:0] CH_OFS_MSR = 4'h6;

  // ----------------------------------------------------------------
  // Fields and reset values
  // ----------------------------------------------------------------
  localparam int TCTL_IRQ_EN = 0;
  localparam int TCTL_START = 1;
  localparam int TCTL_FUNC = 2;
  localparam int TCTL_CLKSRC = 3;
  localparam int BCAST_BIT = 0;
  localparam logic [2:0] CODE_NONE = 3'h0;
  localparam logic [2:0] CODE_TIMER = 3'h7;
  localparam logic [7:0] RST_BYTE = 8'h00;
  localparam logic [7:0] ALL_CH = 8'hff;
  localparam logic [23:0] RST_CODES = 24'h000000;

  // Host access sequencer, Gray coded along idle -> wait -> hold
  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_RDWAIT = 2'b01,
    ST_HOLD = 2'b11
  } ocg_state_t;

endpackage
